/* File: fcsc_pkg.sv */
package fcsc_pkg;
    localparam int unsigned RC_W = 12;
    localparam int unsigned ID_W = 10;
    localparam int unsigned CNT_W = 4;
    localparam int unsigned SLOT_W = 11;
    localparam int unsigned SYNC_MAX_DEF = 15;
    localparam logic [RC_W-1:0] RATE_RST = 12'h000;
    localparam logic [7:0] INIT_SCHED_MT = 8'h10;
    localparam logic [1:0] BRP_10M = 2'h0;
    localparam logic [1:0] BRP_5M = 2'h1;
    localparam logic [1:0] BRP_2M5 = 2'h2;
    localparam logic [2:0] DIV_10M = 3'h1;
    localparam logic [2:0] DIV_5M = 3'h2;
    localparam logic [2:0] DIV_2M5 = 3'h4;

    typedef enum logic [2:0] {
        FCSC_READY = 3'b000,
        FCSC_INIT_SCHED = 3'b001,
        FCSC_INTEG_CHECK = 3'b010,
        FCSC_NORM_ACTIVE = 3'b011,
        FCSC_NORM_PASSIVE = 3'b100,
        FCSC_HALT = 3'b101
    } fcsc_poc_t;

    typedef struct packed {
        logic allow_halt;
        logic [CNT_W-1:0] sync_node_max;
        logic [CNT_W-1:0] max_wo_corr_passive;
        logic [RC_W-1:0] drift_damping;
        logic [RC_W-1:0] micro_init_offset;
        logic [RC_W-1:0] offset_corr_out;
        logic [7:0] dyn_idle_phase;
        logic [1:0] bit_rate_prescaler_field;
        logic loop_back_en;
    } fcsc_cfg_t;

    // Magnitude of a signed correction, unsigned result
    function automatic logic [RC_W-1:0] fcsc_abs(input logic [RC_W-1:0] v);
        return v[RC_W-1] ? RC_W'(-v) : v;
    endfunction : fcsc_abs
endpackage : fcsc_pkg

/* File: fcsc_rate_calc.sv */
`timescale 1ns/100ps
module fcsc_rate_calc (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Double cycle result
    input wire logic calc_valid,
    input wire logic missing,
    input wire logic init_load,
    input wire logic [fcsc_pkg::RC_W-1:0] term,
    // Configuration
    input wire logic [fcsc_pkg::RC_W-1:0] damping,
    input wire logic [fcsc_pkg::RC_W-1:0] init_offset,
    // Applied value
    output logic [fcsc_pkg::RC_W-1:0] rate_r
);
    logic [fcsc_pkg::RC_W:0] sum_w;
    logic ovf_w;
    logic [fcsc_pkg::RC_W-1:0] sat_w;
    logic in_window_w;
    logic [fcsc_pkg::RC_W-1:0] rate_nxt;

    // Saturating sum, then the damping window forces zero
    assign sum_w = {rate_r[fcsc_pkg::RC_W-1], rate_r}
        + {term[fcsc_pkg::RC_W-1], term};
    assign ovf_w = sum_w[fcsc_pkg::RC_W] != sum_w[fcsc_pkg::RC_W-1];
    assign sat_w = ovf_w ? (sum_w[fcsc_pkg::RC_W] ? 12'h800 : 12'h7FF)
        : sum_w[fcsc_pkg::RC_W-1:0];
    assign in_window_w = fcsc_pkg::fcsc_abs(sat_w) <= damping;
    assign rate_nxt = in_window_w ? fcsc_pkg::RATE_RST : sat_w;

    // Missing term holds the old value; the field shows what is applied
    always_ff @(posedge clk) begin
        if (rst) begin
            rate_r <= fcsc_pkg::RATE_RST;
        end else if (init_load) begin
            rate_r <= init_offset;
        end else if (calc_valid && !missing) begin
            rate_r <= rate_nxt;
        end
    end

    property p_missing_hold;
        @(posedge clk) disable iff (rst)
        calc_valid && missing && !init_load |=> rate_r == $past(rate_r);
    endproperty
    a_missing_hold: assert property (p_missing_hold)
        else $error("rate correction changed on missing term");

    property p_damp_zero;
        @(posedge clk) disable iff (rst)
        calc_valid && !missing && !init_load
            |=> rate_r == 12'h000
            || fcsc_pkg::fcsc_abs(rate_r) > $past(damping);
    endproperty
    a_damp_zero: assert property (p_damp_zero)
        else $error("rate inside damping window not zero");
endmodule : fcsc_rate_calc

/* File: fcsc_loopback.sv */
`timescale 1ns/100ps
module fcsc_loopback (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic [1:0] bit_rate_prescaler_field,
    input wire logic loop_back_en,
    // Bit streams
    input wire logic tx_bit,
    input wire logic bus_rx,
    output logic bit_tick,
    output logic rx_bit_r
);
    logic [2:0] div_w;
    logic [2:0] cnt_r;

    // Reserved code 11 falls back to the fastest rate
    assign div_w = (bit_rate_prescaler_field == fcsc_pkg::BRP_5M)
        ? fcsc_pkg::DIV_5M
        : (bit_rate_prescaler_field == fcsc_pkg::BRP_2M5)
        ? fcsc_pkg::DIV_2M5 : fcsc_pkg::DIV_10M;
    assign bit_tick = cnt_r >= div_w - 3'h1;

    // Bit timing divider
    always_ff @(posedge clk) begin
        if (rst || bit_tick) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
        end
    end

    // Same sampling path at every rate, so loop back stays unaltered
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_bit_r <= 1'b1;
        end else if (bit_tick) begin
            rx_bit_r <= loop_back_en ? tx_bit : bus_rx;
        end
    end

    property p_lb_data;
        @(posedge clk) disable iff (rst)
        bit_tick && loop_back_en |=> rx_bit_r == $past(tx_bit);
    endproperty
    a_lb_data: assert property (p_lb_data)
        else $error("loop back data altered");

    property p_lb_slow;
        @(posedge clk) disable iff (rst)
        bit_tick && bit_rate_prescaler_field == 2'h2
            && $stable(bit_rate_prescaler_field) |=> !bit_tick [*3];
    endproperty
    a_lb_slow: assert property (p_lb_slow)
        else $error("2.5 MBit/s bit period wrong");
endmodule : fcsc_loopback

/* File: fcsc_top.sv */
`timescale 1ns/100ps
module fcsc_top #(
    parameter int SYNC_MAX = fcsc_pkg::SYNC_MAX_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire fcsc_pkg::fcsc_cfg_t cfg,
    // Host commands
    input wire logic cmd_run,
    input wire logic cmd_ready,
    // Timebase
    input wire logic mt_tick,
    input wire logic cycle_end,
    input wire logic cycle_odd,
    // Static slot events
    input wire logic sync_frame_valid,
    input wire logic startup_frame,
    input wire logic [fcsc_pkg::ID_W-1:0] frame_id,
    input wire logic [fcsc_pkg::RC_W-1:0] frame_dev,
    input wire logic action_point,
    input wire logic strp_at_ap,
    // Dynamic segment events
    input wire logic in_dynamic,
    input wire logic dyn_slot_tick,
    input wire logic dyn_frame_end,
    input wire logic dyn_idle_detect,
    input wire logic dyn_seg_end,
    // Flag clears
    input wire logic clr_mrcs,
    input wire logic clr_ccf,
    input wire logic clr_sfo,
    // Loop back bit streams
    input wire logic tx_bit,
    input wire logic bus_rx,
    output logic rx_bit,
    output logic bit_tick,
    // Status
    output fcsc_pkg::fcsc_poc_t poc_state,
    output logic missing_rate_corr_flag,
    output logic clock_corr_fail_irq_flag,
    output logic sync_overflow_irq_flag,
    output logic [fcsc_pkg::RC_W-1:0] rate_corr_value_field,
    output logic [fcsc_pkg::RC_W-1:0] offset_corr,
    output logic [fcsc_pkg::CNT_W-1:0] startup_nodes,
    output logic [fcsc_pkg::SLOT_W-1:0] dyn_slot_count,
    output logic dyn_tx_allow
);
    if (SYNC_MAX < 1 || SYNC_MAX > 15) begin : g_chk
        $error("SYNC_MAX must be 1 to 15");
    end

    fcsc_pkg::fcsc_poc_t st_r, st_nxt;
    logic [fcsc_pkg::ID_W-1:0] even_id_r [SYNC_MAX];
    logic [fcsc_pkg::RC_W-1:0] even_dev_r [SYNC_MAX];
    logic [fcsc_pkg::CNT_W-1:0] even_cnt_r, distinct_r, pair_cnt_r;
    logic [fcsc_pkg::CNT_W-1:0] startup_cnt_r, wo_r, wo_nxt;
    logic [fcsc_pkg::RC_W-1:0] term_r, off_r;
    logic pend_r, pend_start_r;
    logic [fcsc_pkg::ID_W-1:0] pend_id_r;
    logic [fcsc_pkg::RC_W-1:0] pend_dev_r;
    logic [7:0] init_cnt_r, idle_cnt_r;
    logic idle_wait_r, slot_stop_r;
    logic [SYNC_MAX-1:0] hit_w;
    logic [fcsc_pkg::CNT_W-1:0] hit_idx_w;
    logic match_w, room_w, commit_w, dbl_end_w, missing_w, sync_st_w;
    logic fail_w, mrcs_set_w, ovf_set_w, in_lim_w, init_load_w;
    logic mrcs_r, ccf_r, sfo_r;

    // Lowest table entry that matches
    function automatic logic [fcsc_pkg::CNT_W-1:0] fcsc_first(
        input logic [SYNC_MAX-1:0] h);
        logic [fcsc_pkg::CNT_W-1:0] idx;
        idx = 4'h0;
        for (int i = SYNC_MAX - 1; i >= 0; i--) begin
            if (h[i]) begin
                idx = fcsc_pkg::CNT_W'(i);
            end
        end
        return idx;
    endfunction : fcsc_first

    // Compare the pending odd frame against the stored even frames
    for (genvar i = 0; i < SYNC_MAX; i++) begin : g_hit
        assign hit_w[i] = (fcsc_pkg::CNT_W'(i) < even_cnt_r)
            && (even_id_r[i] == pend_id_r);
    end
    assign hit_idx_w = fcsc_first(hit_w);
    assign match_w = |hit_w;

    // Sync frame bookkeeping terms
    assign room_w = (distinct_r < cfg.sync_node_max)
        && (even_cnt_r < fcsc_pkg::CNT_W'(SYNC_MAX));
    assign commit_w = pend_r && action_point;
    assign dbl_end_w = cycle_end && cycle_odd;
    assign missing_w = pair_cnt_r == 4'h0;
    assign sync_st_w = (st_r == fcsc_pkg::FCSC_INTEG_CHECK)
        || (st_r == fcsc_pkg::FCSC_NORM_ACTIVE)
        || (st_r == fcsc_pkg::FCSC_NORM_PASSIVE);
    assign wo_nxt = wo_r + 4'h1;
    assign fail_w = dbl_end_w && missing_w && wo_nxt >= cfg.max_wo_corr_passive
        && (st_r == fcsc_pkg::FCSC_NORM_ACTIVE
        || st_r == fcsc_pkg::FCSC_NORM_PASSIVE);
    assign mrcs_set_w = dbl_end_w && missing_w && sync_st_w;
    // Only static sync commits can overflow; slot counter plays no part
    assign ovf_set_w = commit_w && !room_w
        && !(cycle_odd && match_w);
    assign in_lim_w = fcsc_pkg::fcsc_abs(off_r) <= cfg.offset_corr_out;
    assign init_load_w = st_r == fcsc_pkg::FCSC_INIT_SCHED
        && st_nxt == fcsc_pkg::FCSC_INTEG_CHECK;

    // Deviation is captured with the valid frame and committed at the
    // action point; a second reference strobe there does not touch it
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_r <= 1'b0;
            pend_start_r <= 1'b0;
            pend_id_r <= 10'h000;
            pend_dev_r <= 12'h000;
        end else if (sync_frame_valid && !in_dynamic) begin
            pend_r <= 1'b1;
            pend_start_r <= startup_frame;
            pend_id_r <= frame_id;
            pend_dev_r <= frame_dev;
        end else if (action_point || cycle_end) begin
            pend_r <= 1'b0;
        end
    end

    // Even-cycle table; no reset needed as the count guards the entries
    always_ff @(posedge clk) begin
        if (commit_w && !cycle_odd && room_w) begin
            even_id_r[even_cnt_r] <= pend_id_r;
            even_dev_r[even_cnt_r] <= pend_dev_r;
        end
    end

    // Counters of one double cycle
    always_ff @(posedge clk) begin
        if (rst || dbl_end_w || st_r == fcsc_pkg::FCSC_READY) begin
            even_cnt_r <= 4'h0;
            distinct_r <= 4'h0;
            pair_cnt_r <= 4'h0;
            startup_cnt_r <= 4'h0;
            term_r <= 12'h000;
        end else if (commit_w && !cycle_odd) begin
            if (room_w) begin
                even_cnt_r <= even_cnt_r + 4'h1;
                distinct_r <= distinct_r + 4'h1;
                startup_cnt_r <= startup_cnt_r
                    + {3'h0, pend_start_r};
            end
        end else if (commit_w && cycle_odd) begin
            if (match_w) begin
                // A pair counts even past the distinct maximum
                pair_cnt_r <= pair_cnt_r + 4'h1;
                term_r <= term_r + pend_dev_r - even_dev_r[hit_idx_w];
            end else if (room_w) begin
                distinct_r <= distinct_r + 4'h1;
            end
        end
    end

    // Offset measured from the first pair of the double cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            off_r <= 12'h000;
        end else if (commit_w && cycle_odd && match_w && missing_w) begin
            off_r <= pend_dev_r;
        end
    end

    // Protocol state sequencing
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            fcsc_pkg::FCSC_READY: begin
                if (cmd_run) begin
                    st_nxt = fcsc_pkg::FCSC_INIT_SCHED;
                end
            end
            fcsc_pkg::FCSC_INIT_SCHED: begin
                if (mt_tick && init_cnt_r == 8'h01) begin
                    st_nxt = fcsc_pkg::FCSC_INTEG_CHECK;
                end
            end
            fcsc_pkg::FCSC_INTEG_CHECK: begin
                if (dbl_end_w && missing_w) begin
                    st_nxt = fcsc_pkg::FCSC_READY;
                end else if (dbl_end_w && in_lim_w) begin
                    st_nxt = fcsc_pkg::FCSC_NORM_ACTIVE;
                end
            end
            fcsc_pkg::FCSC_NORM_ACTIVE, fcsc_pkg::FCSC_NORM_PASSIVE: begin
                if (fail_w) begin
                    st_nxt = cfg.allow_halt ? fcsc_pkg::FCSC_HALT
                        : fcsc_pkg::FCSC_NORM_PASSIVE;
                end else if (dbl_end_w && !missing_w) begin
                    st_nxt = fcsc_pkg::FCSC_NORM_ACTIVE;
                end
            end
            fcsc_pkg::FCSC_HALT: begin
                st_nxt = fcsc_pkg::FCSC_HALT;
            end
            default: begin
                st_nxt = fcsc_pkg::FCSC_READY;
            end
        endcase
        if (cmd_ready && st_r != fcsc_pkg::FCSC_HALT) begin
            st_nxt = fcsc_pkg::FCSC_READY;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= fcsc_pkg::FCSC_READY;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Reloaded in every non-init state, so no abort leaves it part spent
    always_ff @(posedge clk) begin
        if (rst || st_r != fcsc_pkg::FCSC_INIT_SCHED) begin
            init_cnt_r <= fcsc_pkg::INIT_SCHED_MT;
        end else if (mt_tick) begin
            init_cnt_r <= init_cnt_r - 8'h01;
        end
    end

    // Cycles without clock correction and the offset to apply
    always_ff @(posedge clk) begin
        if (rst || !sync_st_w) begin
            wo_r <= 4'h0;
            offset_corr <= 12'h000;
        end else if (dbl_end_w) begin
            wo_r <= missing_w ? wo_nxt : 4'h0;
            if (!missing_w && in_lim_w) begin
                offset_corr <= 12'(-off_r);
            end
        end
    end

    // Sticky flags; a set in the clear cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            mrcs_r <= 1'b0;
            ccf_r <= 1'b0;
            sfo_r <= 1'b0;
        end else begin
            mrcs_r <= mrcs_set_w || (mrcs_r && !clr_mrcs);
            ccf_r <= fail_w || (ccf_r && !clr_ccf);
            sfo_r <= ovf_set_w || (sfo_r && !clr_sfo);
        end
    end

    // Startup node count seen in the last double cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            startup_nodes <= 4'h0;
        end else if (dbl_end_w) begin
            startup_nodes <= startup_cnt_r;
        end
    end

    // Late idle after a dynamic frame freezes slot counting to segment end
    always_ff @(posedge clk) begin
        if (rst || dyn_seg_end || cycle_end) begin
            idle_wait_r <= 1'b0;
            idle_cnt_r <= 8'h00;
            slot_stop_r <= 1'b0;
            dyn_slot_count <= 11'h000;
        end else begin
            if (dyn_frame_end) begin
                idle_wait_r <= 1'b1;
                idle_cnt_r <= 8'h00;
            end else if (dyn_idle_detect) begin
                idle_wait_r <= 1'b0;
            end else if (idle_wait_r && mt_tick) begin
                idle_cnt_r <= idle_cnt_r + 8'h01;
            end
            if (idle_wait_r && idle_cnt_r > cfg.dyn_idle_phase) begin
                slot_stop_r <= 1'b1;
            end
            if (dyn_slot_tick && !slot_stop_r) begin
                dyn_slot_count <= dyn_slot_count + 11'h001;
            end
        end
    end

    assign dyn_tx_allow = in_dynamic && !slot_stop_r
        && st_r == fcsc_pkg::FCSC_NORM_ACTIVE;
    assign poc_state = st_r;
    assign missing_rate_corr_flag = mrcs_r;
    assign clock_corr_fail_irq_flag = ccf_r;
    assign sync_overflow_irq_flag = sfo_r;

    fcsc_rate_calc u_rate (
        .clk(clk),
        .rst(rst),
        .calc_valid(dbl_end_w && sync_st_w),
        .missing(missing_w),
        .init_load(init_load_w),
        .term(term_r),
        .damping(cfg.drift_damping),
        .init_offset(cfg.micro_init_offset),
        .rate_r(rate_corr_value_field)
    );

    fcsc_loopback u_loop (
        .clk(clk),
        .rst(rst),
        .bit_rate_prescaler_field(cfg.bit_rate_prescaler_field),
        .loop_back_en(cfg.loop_back_en),
        .tx_bit(tx_bit),
        .bus_rx(bus_rx),
        .bit_tick(bit_tick),
        .rx_bit_r(rx_bit)
    );

    property p_ccf_halt;
        @(posedge clk) disable iff (rst)
        fail_w && cfg.allow_halt && !cmd_ready
            |=> poc_state == fcsc_pkg::FCSC_HALT && clock_corr_fail_irq_flag;
    endproperty
    a_ccf_halt: assert property (p_ccf_halt)
        else $error("no halt after correction failure");

    property p_ccf_passive;
        @(posedge clk) disable iff (rst)
        fail_w && !cfg.allow_halt && !cmd_ready
            |=> poc_state == fcsc_pkg::FCSC_NORM_PASSIVE;
    endproperty
    a_ccf_passive: assert property (p_ccf_passive)
        else $error("no passive after correction failure");

    property p_mrcs;
        @(posedge clk) disable iff (rst)
        dbl_end_w && missing_w && sync_st_w |=> missing_rate_corr_flag;
    endproperty
    a_mrcs: assert property (p_mrcs)
        else $error("missing rate flag not set");

    property p_pair;
        @(posedge clk) disable iff (rst)
        commit_w && cycle_odd && match_w && !cycle_end && sync_st_w
            |=> pair_cnt_r == $past(pair_cnt_r) + 4'h1;
    endproperty
    a_pair: assert property (p_pair)
        else $error("matching sync pair dropped");

    property p_startup;
        @(posedge clk) disable iff (rst)
        commit_w && !cycle_odd && !room_w && !cycle_end
            |=> $stable(startup_cnt_r);
    endproperty
    a_startup: assert property (p_startup)
        else $error("startup frame counted past maximum");

    property p_sfo_src;
        @(posedge clk) disable iff (rst)
        $rose(sync_overflow_irq_flag) |-> $past(commit_w) && !$past(room_w);
    endproperty
    a_sfo_src: assert property (p_sfo_src)
        else $error("overflow flag without static overflow");

    property p_init_len;
        @(posedge clk) disable iff (rst)
        poc_state == fcsc_pkg::FCSC_INIT_SCHED && init_cnt_r > 8'h01
            && !cmd_ready |=> poc_state == fcsc_pkg::FCSC_INIT_SCHED;
    endproperty
    a_init_len: assert property (p_init_len)
        else $error("schedule init ended early");

    property p_slot_stop;
        @(posedge clk) disable iff (rst)
        slot_stop_r && !dyn_seg_end && !cycle_end |=> $stable(dyn_slot_count);
    endproperty
    a_slot_stop: assert property (p_slot_stop)
        else $error("slot counting continued after late idle");

    property p_dev_keep;
        @(posedge clk) disable iff (rst)
        pend_r && strp_at_ap && !sync_frame_valid |=> $stable(pend_dev_r);
    endproperty
    a_dev_keep: assert property (p_dev_keep)
        else $error("valid frame deviation overwritten");

    property p_integ;
        @(posedge clk) disable iff (rst)
        poc_state == fcsc_pkg::FCSC_INTEG_CHECK && dbl_end_w && !missing_w
            && in_lim_w && !cmd_ready
            |=> poc_state == fcsc_pkg::FCSC_NORM_ACTIVE;
    endproperty
    a_integ: assert property (p_integ)
        else $error("integration did not reach normal active");
endmodule : fcsc_top

/* File: fcsc_cluster_model.sv */
`timescale 1ns/100ps
// Far side: one sync frame per static slot, bus idles recessive high
module fcsc_cluster_model (
    // Clock
    input wire logic clk,
    // Frame events towards the node
    output logic sfv,
    output logic ap,
    output logic strp,
    output logic bus,
    output logic [9:0] id,
    output logic [11:0] dev
);
    // Idle levels
    initial begin
        {sfv, ap, strp} = 3'h0;
        bus = 1'b1;
        id = 10'h000;
        dev = 12'h000;
    end
    // Fields are inverted after the commit so no stale value looks valid
    task send(input logic [9:0] i, input logic [11:0] d, input logic s);
        @(posedge clk);
        {sfv, id, dev} <= {1'b1, i, d};
        @(posedge clk);
        sfv <= 1'b0;
        @(posedge clk);
        {ap, strp} <= {1'b1, s};
        @(posedge clk);
        {ap, strp, id, dev} <= {2'b00, ~i, ~d};
    endtask : send
endmodule : fcsc_cluster_model

/* File: test_flexray_clock_sync_control.sv */
`timescale 1ns/100ps
module test_flexray_clock_sync_control;
    // Select bits of the shared pulse vector
    localparam logic [11:0] RUN = 12'h800, RDY = 12'h400, MT = 12'h200;
    localparam logic [11:0] CE = 12'h100, CLR = 12'h0C0, DFE = 12'h020;
    localparam logic [11:0] TCK = 12'h010, SEGE = 12'h008;
    logic clk, rst, cycle_odd, in_dynamic, tx_bit, rx_bit, bit_tick;
    logic cmd_run, cmd_ready, mt_tick, cycle_end, clr_mrcs, clr_ccf, clr_sfo;
    logic dyn_frame_end, dyn_slot_tick, dyn_seg_end, dyn_idle_detect;
    logic sfv, ap, strp, bus, mrc, ccf, sfo, txa;
    logic [9:0] fid;
    logic [11:0] pl, fdev, rate_corr_value_reg, offs;
    logic [10:0] slots;
    logic [3:0] sn;
    fcsc_pkg::fcsc_cfg_t cfg;
    fcsc_pkg::fcsc_poc_t st;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    assign {cmd_run, cmd_ready, mt_tick, cycle_end, clr_mrcs, clr_ccf,
        dyn_frame_end, dyn_slot_tick, dyn_seg_end, dyn_idle_detect,
        clr_sfo} = pl[11:1];
    fcsc_cluster_model cl (.clk(clk), .sfv(sfv), .ap(ap), .strp(strp),
        .bus(bus), .id(fid), .dev(fdev));
    fcsc_top dut (.clk(clk), .rst(rst), .cfg(cfg), .cmd_run(cmd_run),
        .cmd_ready(cmd_ready), .mt_tick(mt_tick), .cycle_end(cycle_end),
        .cycle_odd(cycle_odd), .sync_frame_valid(sfv), .startup_frame(1'b1),
        .frame_id(fid), .frame_dev(fdev), .action_point(ap),
        .strp_at_ap(strp), .in_dynamic(in_dynamic),
        .dyn_slot_tick(dyn_slot_tick), .dyn_frame_end(dyn_frame_end),
        .dyn_idle_detect(dyn_idle_detect), .dyn_seg_end(dyn_seg_end),
        .clr_mrcs(clr_mrcs), .clr_ccf(clr_ccf), .clr_sfo(clr_sfo),
        .tx_bit(tx_bit), .bus_rx(bus), .rx_bit(rx_bit), .bit_tick(bit_tick),
        .poc_state(st), .missing_rate_corr_flag(mrc),
        .clock_corr_fail_irq_flag(ccf), .sync_overflow_irq_flag(sfo),
        .rate_corr_value_field(rate_corr_value_reg), .offset_corr(offs), .startup_nodes(sn),
        .dyn_slot_count(slots), .dyn_tx_allow(txa));
    // 40 ns clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Tests need under 1000 cycles, so a hang is cut at cycle 5000
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task chk(input string n, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One-cycle pulses, then let their effects land
    task pulse(input logic [11:0] m, input int n);
        repeat (n) begin
            @(posedge clk);
            pl <= m;
            @(posedge clk);
            pl <= 12'h000;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse
    // Even then odd cycle, optionally with a sync frame in each
    task dcyc(input logic [11:0] de, dodd, input logic fr, s);
        cycle_odd <= 1'b0;
        if (fr) cl.send(10'h005, de, 1'b0);
        pulse(CE, 1);
        cycle_odd <= 1'b1;
        if (fr) cl.send(10'h005, dodd, s);
        pulse(CE, 1);
    endtask : dcyc
    task tally_and_finish();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial begin
        cfg = '{1'b0, 4'h4, 4'h1, 12'h002, 12'h001,
            12'h008, 8'h04, 2'h0, 1'b1};
        {rst, pl, cycle_odd, in_dynamic, tx_bit} = {1'b1, 12'h000, 3'h1};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            int n;
            cfg.bit_rate_prescaler_field <= 2'(k);
            tx_bit <= k[0];
            repeat (8) @(posedge clk);
            #1 chk("rx_bit", 12'(k & 1), 12'(rx_bit));
            n = 0;
            repeat (8) begin
                @(posedge clk);
                #1 n += int'(bit_tick);
            end
            chk("bit_tick", 12'(8 >> k), 12'(n));
        end
        // Without loop back the sampled bit follows the idle bus
        cfg.loop_back_en <= 1'b0;
        repeat (8) @(posedge clk);
        #1 chk("rx_bus", 12'h001, 12'(rx_bit));
        pulse(RUN, 1);
        pulse(MT, 5);
        pulse(RDY, 1);
        chk("state", 12'h000, 12'(st));
        pulse(RUN, 1);
        pulse(MT, 15);
        chk("state", 12'h001, 12'(st));
        pulse(MT, 1);
        chk("state", 12'h002, 12'(st));
        dcyc(12'h000, 12'h003, 1'b1, 1'b0);
        chk("state", 12'h003, 12'(st));
        chk("offset", 12'hFFD, offs);
        chk("rate", 12'h004, rate_corr_value_reg);
        dcyc(12'h000, 12'h000, 1'b0, 1'b0);
        chk("state", 12'h004, 12'(st));
        chk("flags", 12'h003, {10'h000, mrc, ccf});
        chk("rate", 12'h004, rate_corr_value_reg);
        pulse(CLR, 1);
        chk("flags", 12'h000, {10'h000, mrc, ccf});
        dcyc(12'h000, 12'hFFD, 1'b1, 1'b1);
        chk("state", 12'h003, 12'(st));
        chk("rate", 12'h000, rate_corr_value_reg);
        in_dynamic <= 1'b1;
        pulse(TCK, 2);
        chk("tx_allow", 12'h001, 12'(txa));
        pulse(DFE, 1);
        pulse(MT, 6);
        pulse(TCK, 3);
        chk("slots", 12'h002, 12'(slots));
        chk("tx_allow", 12'h000, 12'(txa));
        chk("sfo", 12'h000, 12'(sfo));
        pulse(SEGE, 1);
        in_dynamic <= 1'b0;
        // One sync node allowed: second even frame overflows, pair still holds
        cfg.sync_node_max <= 4'h1;
        cycle_odd <= 1'b0;
        cl.send(10'h005, 12'h000, 1'b0);
        cl.send(10'h006, 12'h000, 1'b0);
        pulse(CE, 1);
        cycle_odd <= 1'b1;
        cl.send(10'h006, 12'h000, 1'b0);
        cl.send(10'h005, 12'h000, 1'b0);
        pulse(CE, 1);
        chk("state", 12'h003, 12'(st));
        chk("sfo", 12'h001, 12'(sfo));
        chk("startup", 12'h001, 12'(sn));
        cfg.allow_halt <= 1'b1;
        dcyc(12'h000, 12'h000, 1'b0, 1'b0);
        pulse(RDY, 1);
        chk("state", 12'h005, 12'(st));
        tally_and_finish();
    end
endmodule : test_flexray_clock_sync_control
